// *** src/tdtd_detector.sv ***
// Time-domain transient detector top module
`timescale 1ns/1ps
module tdtd_detector #(
	parameter int SW    = 16,     // Sample width
	parameter int EW    = 48,     // Segment energy width
	parameter int FS_HZ = 16000   // Input sampling rate
) (
	input  wire logic                      MCLK_IN,     // System clock
	input  wire logic                      RST_IN,      // Asynchronous reset, high
	input  wire logic signed [SW-1:0]      SAMPLE_IN,   // Prefiltered input sample
	input  wire logic                      VALID_IN,    // Sample valid
	output logic                           READY_OUT,   // Sample accepted when high
	input  wire tdtd_pkg::tdtd_context_type CONTEXT_IN, // Coding context, taken at frame start
	output tdtd_pkg::tdtd_result_type      RESULT_OUT,  // Frame decisions
	output logic                           VALID_OUT    // One-cycle result strobe
);
	localparam int SEG_LEN = tdtd_pkg::SEG_TIME_NS / (tdtd_pkg::NS_PER_S / FS_HZ);
	localparam int CW  = $clog2(SEG_LEN + 1);
	localparam int YW  = SW + 3;
	localparam int NW  = EW + tdtd_pkg::FRAC;
	localparam logic [CW-1:0] LAST_SAMPLE = CW'(SEG_LEN - 1);
	localparam logic [5:0]    DIV_STEPS   = 6'(NW - 1);
	tdtd_pkg::tdtd_state_type state;
	tdtd_pkg::tdtd_context_type ctx;
	logic signed [SW-1:0] x1, x2;
	logic [CW-1:0]        sample_cnt;
	logic [2:0]           seg;
	logic [EW-1:0]        energy_acc, acc_energy;
	logic [EW-1:0]        energy [0:tdtd_pkg::TOTAL-1];
	logic [tdtd_pkg::QW-1:0] ratio [0:tdtd_pkg::TOTAL-1];
	logic                 transient, attack_found;
	logic [2:0]           attack_idx;
	logic [NW-1:0]        dvd, quo;
	logic [EW:0]          rem;
	logic [EW-1:0]        den;
	logic [5:0]           div_cnt;
	logic                 div_zero;                 // Both energies zero, ratio is unity
	logic [tdtd_pkg::QW+4:0] flat_sum;
	logic [4:0]           flat_cnt;
	////////////////////////////////////////////////////////////////////////
	// Datapath: filter, energy, detection
	logic                  take;
	logic                  seg_end;
	logic signed [YW-1:0]  filt;
	logic [2*YW-1:0]       square;
	logic [EW-1:0]         next_energy, e_prev, next_acc;
	logic [EW+5:0]         decayed;
	assign READY_OUT = (state == tdtd_pkg::TDTD_RUN);
	assign take      = READY_OUT && VALID_IN;
	assign seg_end   = take && (sample_cnt == LAST_SAMPLE);
	// Filter output scaled by eight keeps the taps exact integers
	assign filt = YW'(tdtd_pkg::FILT_C0) * YW'(SAMPLE_IN)
		- YW'(tdtd_pkg::FILT_C1) * YW'(x1)
		+ YW'(tdtd_pkg::FILT_C2) * YW'(x2);
	assign square      = (2*YW)'(filt * filt);                        // Full-width square
	assign next_energy = energy_acc + EW'(square);
	assign e_prev      = energy[tdtd_pkg::HIST - 1 + int'(seg)];
	assign decayed     = ((EW+6)'(acc_energy) * (EW+6)'(tdtd_pkg::DECAY_NUM))
		>> tdtd_pkg::DECAY_SHIFT;
	assign next_acc    = (e_prev > EW'(decayed)) ? e_prev : EW'(decayed);
	// Filter delay line, kept across frames
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			x1 <= '0;
			x2 <= '0;
		end else if (take) begin
			x1 <= SAMPLE_IN;
			x2 <= x1;
		end
	end
	// Sample counting and energy summation within a segment
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sample_cnt <= '0;
			energy_acc <= '0;
		end else if (take) begin
			sample_cnt <= seg_end ? '0 : sample_cnt + CW'(1);
			energy_acc <= seg_end ? '0 : next_energy;
		end
	end
	// Context capture at first sample of a frame
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ctx <= '0;
		end else if (take && seg == 3'h0 && sample_cnt == '0) begin
			ctx <= CONTEXT_IN;
		end
	end
	// Accumulated energy and transient tests at segment end
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			acc_energy   <= '0;
			transient    <= 1'b0;
			attack_found <= 1'b0;
			attack_idx   <= 3'h0;
		end else if (state == tdtd_pkg::TDTD_OUT) begin
			transient    <= 1'b0;
			attack_found <= 1'b0;
			attack_idx   <= 3'h0;
		end else if (seg_end) begin
			acc_energy <= next_acc;
			if (((EW+6)'(next_energy) << tdtd_pkg::ATTACK_SHIFT) >
				(EW+6)'(next_acc) * (EW+6)'(tdtd_pkg::ATTACK_NUM)) begin
				transient    <= 1'b1;
				attack_found <= 1'b1;
				attack_idx   <= seg;
			end else if (!transient &&
				(EW+6)'(next_energy) > (EW+6)'(next_acc) * (EW+6)'(tdtd_pkg::STRONG_NUM)) begin
				attack_found <= 1'b1;
				attack_idx   <= seg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared restoring divider, one quotient bit per cycle
	logic [EW:0] trial;
	logic        fits;
	assign trial = {rem[EW-1:0], dvd[NW-1]};
	assign fits  = (trial >= {1'b0, den});
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			dvd      <= '0;
			den      <= '0;
			rem      <= '0;
			quo      <= '0;
			div_zero <= 1'b0;
		end else if (seg_end) begin
			// Larger of the two energies over the smaller
			dvd      <= {(next_energy > e_prev ? next_energy : e_prev),
				tdtd_pkg::FRAC'(0)};
			den      <= (next_energy > e_prev) ? e_prev : next_energy;
			div_zero <= (next_energy == '0) && (e_prev == '0);  // One zero divides by zero, saturates
			rem      <= '0;
			quo      <= '0;
		end else if (state == tdtd_pkg::TDTD_DIV && div_cnt == DIV_STEPS && seg == 3'h7) begin
			dvd      <= NW'(flat_sum);
			den      <= EW'(flat_cnt);
			div_zero <= 1'b0;
			rem      <= '0;
			quo      <= '0;
		end else if (state == tdtd_pkg::TDTD_DIV || state == tdtd_pkg::TDTD_FDIV) begin
			rem <= fits ? trial - {1'b0, den} : trial;
			quo <= {quo[NW-2:0], fits};
			dvd <= {dvd[NW-2:0], 1'b0};
		end
	end

	// Ratio with saturation; equal zero energies give unity
	logic [NW-1:0]           quo_final;
	logic [tdtd_pkg::QW-1:0] ratio_new;
	assign quo_final = {quo[NW-2:0], fits};
	always_comb begin
		ratio_new = quo_final[tdtd_pkg::QW-1:0];
		if (div_zero) begin
			ratio_new = tdtd_pkg::RATIO_ONE;
		end else if (quo_final[NW-1:tdtd_pkg::QW] != '0) begin
			ratio_new = tdtd_pkg::RATIO_SAT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Past segment count from pitch lag, rounded and capped
	logic [tdtd_pkg::NPAST_CAP:1] lag_ge;
	logic [3:0]                   rounded, npast;
	logic [14:0]                  lag_scaled;
	assign lag_scaled = {ctx.pitch_lag, 4'h0} + 15'(ctx.core_len);
	for (genvar q = 1; q <= tdtd_pkg::NPAST_CAP; q++) begin : g_round
		assign lag_ge[q] = lag_scaled >= 15'(2 * q) * 15'(ctx.core_len);
	end
	always_comb begin
		rounded = 4'h0;
		for (int q = 1; q <= tdtd_pkg::NPAST_CAP; q++) begin
			rounded = rounded + 4'(lag_ge[q]);
		end
		npast = ctx.ltp_decision ? rounded + 4'h1 : 4'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Frame-level scan: flatness sum, extremes, new count, peak change
	logic [4:0]              start, i_max, i_min;
	logic signed [5:0]       nnew;
	logic [tdtd_pkg::QW-1:0] peak;
	logic [EW+3:0]           e_min_sc, e_max_sc;
	always_comb begin
		start    = 5'(tdtd_pkg::HIST) - 5'(npast);
		flat_cnt = 5'(tdtd_pkg::SEG_COUNT) + 5'(npast);
		flat_sum = '0;
		i_max    = start;
		i_min    = start;
		for (int k = 0; k < tdtd_pkg::TOTAL; k++) begin
			if (5'(k) >= start) begin
				flat_sum = flat_sum + (tdtd_pkg::QW+5)'((k == tdtd_pkg::TOTAL - 1) ?
					ratio_new : ratio[k]);                // Newest ratio not yet stored at load
				if (energy[k] > energy[i_max]) i_max = 5'(k);
				if (energy[k] < energy[i_min]) i_min = 5'(k);
			end
		end
		e_min_sc = (EW+4)'(energy[i_min]) << tdtd_pkg::FLAT_MIN_SHIFT;
		e_max_sc = (EW+4)'(energy[i_max]) * (EW+4)'(tdtd_pkg::FLAT_MIN_NUM);
		if (transient && e_min_sc > e_max_sc) begin
			nnew = 6'(i_max) - 6'(tdtd_pkg::HIST) - 6'(tdtd_pkg::NNEW_OFFSET);
		end else begin
			nnew = 6'(tdtd_pkg::SEG_COUNT);
		end
		peak = ratio[start];
		for (int k = 0; k < tdtd_pkg::TOTAL; k++) begin
			if (5'(k) >= start && $signed(6'(k) - 6'(tdtd_pkg::HIST)) < nnew &&
				ratio[k] > peak) begin
				peak = ratio[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Controller
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state   <= tdtd_pkg::TDTD_RUN;
			seg     <= 3'h0;
			div_cnt <= 6'h00;
		end else begin
			case (state)
				tdtd_pkg::TDTD_RUN: begin
					div_cnt <= 6'h00;
					if (seg_end) state <= tdtd_pkg::TDTD_DIV;
				end
				tdtd_pkg::TDTD_DIV: begin
					div_cnt <= div_cnt + 6'h01;
					if (div_cnt == DIV_STEPS) begin
						div_cnt <= 6'h00;
						seg     <= seg + 3'h1;
						state   <= (seg == 3'h7) ? tdtd_pkg::TDTD_FDIV : tdtd_pkg::TDTD_RUN;
					end
				end
				tdtd_pkg::TDTD_FDIV: begin
					div_cnt <= div_cnt + 6'h01;
					if (div_cnt == DIV_STEPS) state <= tdtd_pkg::TDTD_OUT;
				end
				tdtd_pkg::TDTD_OUT: begin
					div_cnt <= 6'h00;
					state   <= tdtd_pkg::TDTD_RUN;
				end
				default: state <= tdtd_pkg::TDTD_RUN;
			endcase
		end
	end
	// Segment history: current entries written, shifted into past at frame end
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			for (int k = 0; k < tdtd_pkg::TOTAL; k++) begin
				energy[k] <= '0;
				ratio[k]  <= '0;
			end
		end else if (state == tdtd_pkg::TDTD_OUT) begin
			for (int k = 0; k < tdtd_pkg::HIST; k++) begin
				energy[k] <= energy[k + tdtd_pkg::SEG_COUNT];
				ratio[k]  <= ratio[k + tdtd_pkg::SEG_COUNT];
			end
		end else begin
			if (seg_end) energy[tdtd_pkg::HIST + int'(seg)] <= next_energy;
			if (state == tdtd_pkg::TDTD_DIV && div_cnt == DIV_STEPS) begin
				ratio[tdtd_pkg::HIST + int'(seg)] <= ratio_new;
			end
		end
	end
	// Result registers and strobe
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			RESULT_OUT <= '0;
			VALID_OUT  <= 1'b0;
		end else begin
			VALID_OUT <= (state == tdtd_pkg::TDTD_FDIV && div_cnt == DIV_STEPS);
			if (state == tdtd_pkg::TDTD_FDIV && div_cnt == DIV_STEPS) begin
				RESULT_OUT <= {transient, (attack_found ? attack_idx : 3'h0),
					quo_final[tdtd_pkg::QW-1:0], peak};
			end
		end
	end
endmodule

// *** pkg/tdtd_pkg.sv ***
// Constants and carrier types of the time-domain transient detector
package tdtd_pkg;
	localparam int SEG_COUNT     = 8;      // Segments per frame
	localparam int HIST          = 9;      // Trailing segments kept from earlier frames
	localparam int TOTAL         = 17;     // History plus current segments
	localparam int SEG_TIME_NS   = 2500000; // Segment duration in ns (2.5 ms)
	localparam int NS_PER_S      = 1000000000;
	localparam int FRAC          = 8;      // Fraction bits of ratios
	localparam int QW            = 24;     // Width of ratio and flatness results
	localparam int FILT_C0       = 3;      // 0.375 times eight
	localparam int FILT_C1       = 4;      // 0.5 times eight
	localparam int FILT_C2       = 1;      // 0.125 times eight
	localparam int DECAY_NUM     = 13;     // 0.8125 is 13/16
	localparam int DECAY_SHIFT   = 4;
	localparam int ATTACK_NUM    = 17;     // 8.5 is 17/2
	localparam int ATTACK_SHIFT  = 1;
	localparam int STRONG_NUM    = 4;      // Strong increase factor
	localparam int FLAT_MIN_NUM  = 3;      // 0.375 is 3/8
	localparam int FLAT_MIN_SHIFT = 3;
	localparam int NNEW_OFFSET   = 3;
	localparam int NPAST_CAP     = 8;
	localparam logic [QW-1:0] RATIO_ONE = 24'h000100; // 1.0 in ratio format
	localparam logic [QW-1:0] RATIO_SAT = 24'hFFFFFF; // Saturated ratio

	// Controller states, Gray coded along the usual path
	typedef enum logic [1:0] {
		TDTD_RUN  = 2'b00,
		TDTD_DIV  = 2'b01,
		TDTD_FDIV = 2'b11,
		TDTD_OUT  = 2'b10
	} tdtd_state_type;

	// Per-frame decision set
	typedef struct packed {
		logic          transient;
		logic [2:0]    attack_idx;
		logic [QW-1:0] temporal_flatness;
		logic [QW-1:0] peak_energy_change;
	} tdtd_result_type;

	// Coding context of the frame
	typedef struct packed {
		logic       ltp_decision;
		logic [9:0] pitch_lag;
		logic [9:0] core_len;
	} tdtd_context_type;
endpackage

// *** tb/tdtd_detector_chk.sv ***
// Port-level property checker for the transient detector
`timescale 1ns/1ps
module tdtd_detector_chk #(
	parameter int SW    = 16,   // Sample width
	parameter int FS_HZ = 16000 // Sampling rate
) (
	input wire logic                       MCLK_IN,    // Clock
	input wire logic                       RST_IN,     // Reset
	input wire logic signed [SW-1:0]       SAMPLE_IN,  // Sample
	input wire logic                       VALID_IN,   // Sample valid
	input wire logic                       READY_OUT,  // Ready
	input wire tdtd_pkg::tdtd_context_type CONTEXT_IN, // Context
	input wire tdtd_pkg::tdtd_result_type  RESULT_OUT, // Result
	input wire logic                       VALID_OUT   // Strobe
);
	localparam int SEG_LEN   = FS_HZ / 400; // Samples in 2.5 ms
	localparam int FRAME_LEN = 8 * SEG_LEN;
	int   pos;     // Next sample position in frame
	int   low_run; // Cycles with ready low
	logic pend;    // Frame ended, result owed
	logic take;
	assign take = VALID_IN && READY_OUT;
	////////////////////////////////////////////////////////////////
	// Position of the next sample within its frame
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pos <= 0;
		end else if (take) begin
			pos <= (pos == FRAME_LEN - 1) ? 0 : pos + 1;
		end
	end
	// Length of the current run of ready low
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			low_run <= 0;
		end else begin
			low_run <= READY_OUT ? 0 : low_run + 1;
		end
	end
	// Result owed from the end of a frame until the strobe
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pend <= 1'b0;
		end else if (take && pos == FRAME_LEN - 1) begin
			pend <= 1'b1;
		end else if (VALID_OUT) begin
			pend <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	// Properties
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);
	sequence seg_end_taken;
		take && (pos % SEG_LEN == SEG_LEN - 1);
	endsequence
	sequence mid_seg_taken;
		take && (pos % SEG_LEN != SEG_LEN - 1);
	endsequence
	sequence frame_end_taken;
		take && pos == FRAME_LEN - 1;
	endsequence
	AST_SEG_PAUSE: assert property (seg_end_taken |=> !READY_OUT [*8])
		else $error("ready back too soon after segment end");
	AST_MID_SEG: assert property (mid_seg_taken |=> READY_OUT)
		else $error("ready dropped inside a segment");
	AST_PAUSE_LEN: assert property ($rose(READY_OUT) |-> low_run == 56 || low_run == 113)
		else $error("busy span of wrong length");
	AST_RESULT_DUE: assert property (frame_end_taken |-> ##[111:115] VALID_OUT)
		else $error("frame result not delivered in time");
	AST_STROBE_ONCE: assert property (VALID_OUT |=> !VALID_OUT)
		else $error("strobe longer than one cycle");
	AST_STROBE_CAUSE: assert property (VALID_OUT |-> pend)
		else $error("strobe without a finished frame");
	AST_HOLD: assert property (!VALID_OUT |-> $stable(RESULT_OUT))
		else $error("result changed without strobe");
	AST_BUSY_PEND: assert property (pend |-> !READY_OUT)
		else $error("sample accepted before frame result");
endmodule
bind tdtd_detector tdtd_detector_chk #(.SW(SW), .FS_HZ(FS_HZ)) chk_i (
	.MCLK_IN   (MCLK_IN),
	.RST_IN    (RST_IN),
	.SAMPLE_IN (SAMPLE_IN),
	.VALID_IN  (VALID_IN),
	.READY_OUT (READY_OUT),
	.CONTEXT_IN(CONTEXT_IN),
	.RESULT_OUT(RESULT_OUT),
	.VALID_OUT (VALID_OUT)
);

// *** tb/tdtd_source.sv ***
// Upstream sample source feeding one frame at a time
`timescale 1ns/1ps
module tdtd_source #(
	parameter int FRAME_LEN = 32 // Samples per frame
) (
	input  wire logic          clk_in,     // Clock
	input  wire logic          ready_in,   // Detector ready
	output logic signed [15:0] sample_out, // Sample
	output logic               valid_out   // Sample valid
);
	// Idle lines at time zero
	initial begin
		sample_out = 16'sh5A5A;
		valid_out = 1'b0;
	end
	// Pre values before index at, post values from index at on, gap idle cycles between
	task automatic send_frame(input logic signed [15:0] pre, post, input int at, gap);
		logic signed [15:0] v;
		for (int n = 0; n < FRAME_LEN; n++) begin
			v = (n < at) ? pre : post;
			sample_out <= v;
			valid_out <= 1'b1;
			do @(posedge clk_in); while (ready_in !== 1'b1);
			if (gap > 0 || n == FRAME_LEN - 1) begin
				valid_out <= 1'b0;
				sample_out <= ~v;
				repeat (gap) @(posedge clk_in);
			end
		end
	endtask
endmodule

// *** tb/test_time_domain_transient_detector.sv ***
// Self-checking bench for the transient detector
`timescale 1ns/1ps
module test_time_domain_transient_detector;
	localparam int FS = 1600; // Four samples a segment keeps frames short
	logic                       clk;
	logic                       rst;
	logic                       ready;
	logic                       vout;
	logic                       valid;
	logic signed [15:0]         sample;
	tdtd_pkg::tdtd_context_type ctx;
	tdtd_pkg::tdtd_result_type  res;
	int                         errors;
	int                         cmp_count;
	int                         cycles;
	// Clock of 10 ns
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Device and upstream source
	tdtd_detector #(.FS_HZ(FS)) uut (
		.MCLK_IN   (clk),
		.RST_IN    (rst),
		.SAMPLE_IN (sample),
		.VALID_IN  (valid),
		.READY_OUT (ready),
		.CONTEXT_IN(ctx),
		.RESULT_OUT(res),
		.VALID_OUT (vout)
	);
	tdtd_source #(.FRAME_LEN(8 * FS / 400)) src (
		.clk_in    (clk),
		.ready_in  (ready),
		.sample_out(sample),
		.valid_out (valid)
	);
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [51:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask
	// Wait for the frame strobe and judge every field in that cycle
	task automatic expect_frame(input logic tr, input logic [2:0] att, input logic [23:0] fl, pk);
		int n;
		n = 0;
		@(posedge clk);
		while (vout !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("strobe", 52'h1, {51'h0, vout});
		chk("transient", {51'h0, tr}, {51'h0, res.transient});
		chk("attack", {49'h0, att}, {49'h0, res.attack_idx});
		chk("flatness", {28'h0, fl}, {28'h0, res.temporal_flatness});
		chk("peak", {28'h0, pk}, {28'h0, res.peak_energy_change});
	endtask
	////////////////////////////////////////////////////////////////
	// Silent frame: equal energies give unit ratios
	task automatic scn_silent();
		ctx <= '{1'b0, 10'h000, 10'h050};
		src.send_frame(16'sh0000, 16'sh0000, 0, 0);
		expect_frame(1'b0, 3'h0, 24'h000100, 24'h000100);
	endtask
	// Step in segment three over quiet history: transient, saturated ratios
	task automatic scn_attack();
		ctx <= '{1'b0, 10'h000, 10'h050};
		src.send_frame(16'sh0000, 16'sh0010, 12, 0);
		expect_frame(1'b1, 3'h3, 24'h4000BF, 24'hFFFFFF);
	endtask
	// Drop in segment five under a decayed accumulator, five past segments, stalls
	task automatic scn_rise();
		ctx <= '{1'b1, 10'h028, 10'h050};
		src.send_frame(16'sh0010, 16'sh0000, 20, 2);
		expect_frame(1'b0, 3'h5, 24'h4EC59D, 24'hFFFFFF);
	endtask
	// Reset clears history, so the step frame repeats its result
	task automatic scn_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		chk("ready", 52'h1, {51'h0, ready});
		chk("strobe", 52'h0, {51'h0, vout});
		chk("result", 52'h0, res);
		rst <= 1'b0;
		scn_attack();
	endtask
	// Cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			errors++;
			$display("ERROR cycles expected below 10000 seen %0d", cycles);
			tally_and_finish();
		end
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		ctx = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		scn_silent();
		scn_attack();
		scn_rise();
		scn_reset();
		tally_and_finish();
	end
endmodule
